// [dcm_pkg.sv]
// Shared constants and types for the completion and parameter-mapping block
package dcm_pkg;
  localparam int NUM_CH = 64;
  localparam int NUM_SETS = 128;
  localparam int NUM_QCH = 8;
  localparam int SET_WORDS = 8;
  localparam logic [31:0] PM_BASE = 32'h01c0_4000;
  localparam logic [31:0] PM_LAST = 32'h01c0_4fff;
  localparam int SET_BYTES = 32;
  // Word positions inside one set
  localparam logic [2:0] W_CFG = 3'h0;
  localparam logic [2:0] W_CNT = 3'h2;
  localparam logic [2:0] W_LINK = 3'h5;
  localparam logic [2:0] W_CNT3 = 3'h7;
  // Options word fields
  localparam int CFG_SYNC_FRAME = 2;
  localparam int CFG_EARLY = 11;
  localparam int CFG_CODE_LSB = 12;
  localparam int CFG_FINAL_IRQ = 20;
  localparam int CFG_INTER_IRQ = 21;
  localparam int CFG_FINAL_CHAIN = 22;
  localparam int CFG_INTER_CHAIN = 23;
  localparam logic [15:0] NULL_LINK = 16'hffff;
  localparam logic [6:0] QMAP_SET_RST = 7'h00;
  localparam logic [2:0] QMAP_WORD_RST = 3'h0;
  localparam logic [31:0] PM_WORD_RST = 32'h0000_0000;
  localparam logic [63:0] VEC_RST = 64'h0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EVAL = 2'b01,
    ST_SUBMIT = 2'b10,
    ST_LINK = 2'b11
  } dcm_state_type;
  typedef enum logic [1:0] {
    SRC_EVENT = 2'b00,
    SRC_CHAIN = 2'b01,
    SRC_QUICK = 2'b10
  } dcm_src_type;
endpackage

// [dcm_if.sv]
// Request and completion link between channel and transfer controllers
`timescale 1ns/100ps
interface dcm_if;
  logic rq_valid;
  logic rq_ready;
  logic [6:0] rq_set;
  logic [5:0] rq_code;
  logic rq_chain;
  logic rq_irq;
  logic done_valid;
  logic [5:0] done_code;
  logic done_chain;
  logic done_irq;
  modport cc (
    output rq_valid, rq_set, rq_code, rq_chain, rq_irq,
    input rq_ready, done_valid, done_code, done_chain, done_irq
  );
  modport tc (
    input rq_valid, rq_set, rq_code, rq_chain, rq_irq,
    output rq_ready, done_valid, done_code, done_chain, done_irq
  );
endinterface

// [dcm_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module dcm_sync #(
  parameter int WIDTH = 64
) (
  input wire logic clock, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic [WIDTH-1:0] din, // Asynchronous inputs
  output logic [WIDTH-1:0] dout // Filtered level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level moves only where the later stages agree
  always_ff @(posedge clock) begin
    if (reset) begin
      dout <= '0;
    end else if (ce) begin
      dout <= (dout & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
    end
  end
endmodule

// [dcm_xfer_ctrl.sv]
// Transfer controller end: takes requests and returns completion codes
`timescale 1ns/100ps
module dcm_xfer_ctrl (
  input wire logic clock, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic ce, // Clock enable
  dcm_if.tc link, // Channel controller link
  input wire logic dest_done, // Destination peripheral finished
  output logic xfer_active, // Transfer in progress
  output logic [6:0] xfer_set // Set being moved
);
  logic ready_q;
  logic chain_q;
  logic irq_q;
  logic [5:0] code_q;
  logic done_valid_q;
  logic [5:0] done_code_q;
  logic done_chain_q;
  logic done_irq_q;

  assign link.rq_ready = ready_q;
  assign link.done_valid = done_valid_q;
  assign link.done_code = done_code_q;
  assign link.done_chain = done_chain_q;
  assign link.done_irq = done_irq_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      ready_q <= 1'b1;
      xfer_active <= 1'b0;
      xfer_set <= 7'h00;
      chain_q <= 1'b0;
      irq_q <= 1'b0;
      code_q <= 6'h00;
    end else if (ce) begin
      if (link.rq_valid && ready_q) begin
        ready_q <= 1'b0;
        xfer_active <= 1'b1;
        xfer_set <= link.rq_set;
        chain_q <= link.rq_chain;
        irq_q <= link.rq_irq;
        code_q <= link.rq_code;
      end else if (xfer_active && dest_done) begin
        ready_q <= 1'b1;
        xfer_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      done_valid_q <= 1'b0;
      done_code_q <= 6'h00;
      done_chain_q <= 1'b0;
      done_irq_q <= 1'b0;
    end else if (ce) begin
      done_valid_q <= xfer_active && dest_done && (chain_q || irq_q);
      done_code_q <= code_q;
      done_chain_q <= chain_q;
      done_irq_q <= irq_q;
    end
  end
endmodule

// [dcm_channel_ctrl.sv]
// Channel controller end: events, parameter memory, completion codes
//
// Contract
// - Six-bit code picks one of 64 bits
// - Final, intermediate or all requests return codes
// - Transfer controller reports each finished transfer; code reports only those with chain or irq requested
// - Link FFFFh is null link
// - Event on null set flags error; quick events on a null set do not
// - Mode 0: complete on returned code
// - Mode 1: complete at submit, internal code
// - Dummy/null sets: no request, codes still set
// - Sixty-four channels, each with fixed event
// - Unused events leave channel manually usable
// - Channel n always uses set n
// - Sets are 32-byte blocks from base
// - Sets 64-127 only link or quick
// - Quick channel maps to any set
// - Write to trigger word fires quick channel
// - Quick channels reset to set 0
// - Counts and sync type size each request
// - Final request sends final codes, links
// - Null service clears pending, sets missed; quick channel null service clears pending but sets no missed bit
// - Chained code sets event, then queued
`timescale 1ns/100ps
module dcm_channel_ctrl (
  input wire logic clock, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic ce, // Clock enable
  dcm_if.cc link, // Transfer controller link
  input wire logic [63:0] hw_event, // Peripheral events, asynchronous
  input wire logic [63:0] manual_set, // Manual trigger pulses
  input wire logic pm_we, // Parameter memory write
  input wire logic pm_re, // Parameter memory read
  input wire logic [31:0] pm_addr, // Byte address
  input wire logic [31:0] pm_wdata, // Write data
  output logic [31:0] pm_rdata, // Read data
  input wire logic qmap_we, // Quick map write
  input wire logic [2:0] qmap_sel, // Quick channel selected
  input wire logic [6:0] qmap_set, // Mapped set
  input wire logic [2:0] qmap_word, // Trigger word
  input wire logic [7:0] quick_enable, // Quick channel enables
  input wire logic [63:0] chain_clear, // Chained event clear mask
  input wire logic [63:0] irq_clear, // Irq pending clear mask
  input wire logic [63:0] missed_clear, // Missed event clear mask
  output logic [63:0] event_pending_reg, // Pending hardware/manual events
  output logic [63:0] chained_event_reg, // Chained events
  output logic [63:0] irq_pending_reg, // Interrupt pending bits
  output logic [63:0] event_missed_reg, // Missed events
  output logic [7:0] quick_pending, // Quick events pending
  output logic null_error // Null set serviced
);
  function automatic logic [6:0] first_one(input logic [63:0] v);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [63:0] code_bit(input logic [5:0] c);
    return 64'h1 << c;
  endfunction

  logic [31:0] pm_q [dcm_pkg::NUM_SETS*dcm_pkg::SET_WORDS];
  logic [6:0] qset_q [dcm_pkg::NUM_QCH];
  logic [2:0] qword_q [dcm_pkg::NUM_QCH];
  dcm_pkg::dcm_state_type state_q;
  dcm_pkg::dcm_src_type src_q;
  logic [6:0] cur_q;
  logic [5:0] idx_q;
  logic [2:0] lcnt_q;
  logic rq_valid_q;
  logic [6:0] rq_set_q;
  logic [5:0] rq_code_q;
  logic rq_chain_q;
  logic rq_irq_q;
  logic [63:0] hw_lvl;
  logic [63:0] hw_prev_q;
  logic [63:0] hw_rise;
  logic sw_hit;
  logic [9:0] sw_idx;
  logic [31:0] cfg;
  logic [15:0] cnt1;
  logic [15:0] cnt2;
  logic [15:0] cnt3;
  logic [15:0] brld;
  logic [15:0] lnk;
  logic is_null;
  logic is_dummy;
  logic is_final;
  logic want_chain;
  logic want_irq;
  logic [5:0] code;
  logic hs;
  logic eval_q_end;
  logic early_fire;
  logic [63:0] chn_set;
  logic [63:0] irq_set;
  logic [63:0] serv_mask;
  logic [63:0] null_mask;
  logic cnt_we;
  logic [31:0] cnt_d;
  logic cnt3_we;
  logic [15:0] cnt3_d;
  logic copy_we;
  logic [7:0] q_trig;
  logic [6:0] dpick;
  logic [6:0] qpick;

  assign link.rq_valid = rq_valid_q;
  assign link.rq_set = rq_set_q;
  assign link.rq_code = rq_code_q;
  assign link.rq_chain = rq_chain_q;
  assign link.rq_irq = rq_irq_q;

  dcm_sync #(.WIDTH(64)) u_sync (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .din(hw_event),
    .dout(hw_lvl)
  );
  assign hw_rise = hw_lvl & ~hw_prev_q;

  assign sw_hit = (pm_addr >= dcm_pkg::PM_BASE) && (pm_addr <= dcm_pkg::PM_LAST);
  assign sw_idx = pm_addr[11:2];

  always_comb begin
    cfg = pm_q[{cur_q, dcm_pkg::W_CFG}];
    cnt1 = pm_q[{cur_q, dcm_pkg::W_CNT}][15:0];
    cnt2 = pm_q[{cur_q, dcm_pkg::W_CNT}][31:16];
    cnt3 = pm_q[{cur_q, dcm_pkg::W_CNT3}][15:0];
    lnk = pm_q[{cur_q, dcm_pkg::W_LINK}][15:0];
    brld = pm_q[{cur_q, dcm_pkg::W_LINK}][31:16];
    code = cfg[dcm_pkg::CFG_CODE_LSB +: 6];
    is_null = (cnt1 == 16'h0) && (cnt2 == 16'h0) && (cnt3 == 16'h0);
    is_dummy = !is_null && ((cnt1 == 16'h0) || (cnt2 == 16'h0) || (cnt3 == 16'h0));
    if (cfg[dcm_pkg::CFG_SYNC_FRAME]) begin
      is_final = (cnt3 == 16'h1);
    end else begin
      is_final = (cnt2 == 16'h1) && (cnt3 == 16'h1);
    end
    want_chain = is_final ? cfg[dcm_pkg::CFG_FINAL_CHAIN] : cfg[dcm_pkg::CFG_INTER_CHAIN];
    want_irq = is_final ? cfg[dcm_pkg::CFG_FINAL_IRQ] : cfg[dcm_pkg::CFG_INTER_IRQ];
  end

  assign hs = rq_valid_q && link.rq_ready;
  assign eval_q_end = (state_q == dcm_pkg::ST_EVAL);
  assign early_fire = (eval_q_end && (is_null || is_dummy))
    || ((state_q == dcm_pkg::ST_SUBMIT) && hs && cfg[dcm_pkg::CFG_EARLY]);
  assign chn_set = ((early_fire && want_chain) ? code_bit(code) : dcm_pkg::VEC_RST)
    | ((link.done_valid && link.done_chain) ? code_bit(link.done_code) : dcm_pkg::VEC_RST);
  assign irq_set = ((early_fire && want_irq) ? code_bit(code) : dcm_pkg::VEC_RST)
    | ((link.done_valid && link.done_irq) ? code_bit(link.done_code) : dcm_pkg::VEC_RST);
  assign serv_mask = eval_q_end ? code_bit(idx_q) : dcm_pkg::VEC_RST;
  assign null_mask = (eval_q_end && is_null && (src_q != dcm_pkg::SRC_QUICK)) ? serv_mask
    : dcm_pkg::VEC_RST;
  assign dpick = first_one(event_pending_reg | chained_event_reg);
  assign qpick = first_one({56'h0, quick_pending});

  always_comb begin
    cnt_we = 1'b0;
    cnt_d = pm_q[{cur_q, dcm_pkg::W_CNT}];
    cnt3_we = 1'b0;
    cnt3_d = cnt3;
    if ((state_q == dcm_pkg::ST_SUBMIT) && hs && !is_final) begin
      if (cfg[dcm_pkg::CFG_SYNC_FRAME]) begin
        cnt3_we = 1'b1;
        cnt3_d = cnt3 - 16'h1;
      end else if (cnt2 > 16'h1) begin
        cnt_we = 1'b1;
        cnt_d = {cnt2 - 16'h1, cnt1};
      end else begin
        cnt_we = 1'b1;
        cnt_d = {brld, cnt1};
        cnt3_we = 1'b1;
        cnt3_d = cnt3 - 16'h1;
      end
    end else if ((state_q == dcm_pkg::ST_LINK) && (lnk == dcm_pkg::NULL_LINK)) begin
      cnt_we = 1'b1;
      cnt_d = 32'h0;
      cnt3_we = 1'b1;
      cnt3_d = 16'h0;
    end
  end
  assign copy_we = (state_q == dcm_pkg::ST_LINK) && (lnk != dcm_pkg::NULL_LINK);

  for (genvar g = 0; g < dcm_pkg::NUM_QCH; g++) begin : g_qtrig
    assign q_trig[g] = quick_enable[g]
      && ((pm_we && sw_hit && (sw_idx == {qset_q[g], qword_q[g]}))
      || (copy_we && ({cur_q, lcnt_q} == {qset_q[g], qword_q[g]})));
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < dcm_pkg::NUM_SETS*dcm_pkg::SET_WORDS; i++) begin
        pm_q[i] <= dcm_pkg::PM_WORD_RST;
      end
    end else if (ce) begin
      if (pm_we && sw_hit) begin
        pm_q[sw_idx] <= pm_wdata;
      end
      if (cnt_we) begin
        pm_q[{cur_q, dcm_pkg::W_CNT}] <= cnt_d;
      end
      if (cnt3_we) begin
        pm_q[{cur_q, dcm_pkg::W_CNT3}] <= {pm_q[{cur_q, dcm_pkg::W_CNT3}][31:16], cnt3_d};
      end
      if (copy_we) begin
        pm_q[{cur_q, lcnt_q}] <= pm_q[{lnk[11:5], lcnt_q}];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pm_rdata <= 32'h0;
    end else if (ce && pm_re) begin
      pm_rdata <= sw_hit ? pm_q[sw_idx] : 32'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < dcm_pkg::NUM_QCH; i++) begin
        qset_q[i] <= dcm_pkg::QMAP_SET_RST;
        qword_q[i] <= dcm_pkg::QMAP_WORD_RST;
      end
    end else if (ce && qmap_we) begin
      qset_q[qmap_sel] <= qmap_set;
      qword_q[qmap_sel] <= qmap_word;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      hw_prev_q <= dcm_pkg::VEC_RST;
      event_pending_reg <= dcm_pkg::VEC_RST;
      quick_pending <= 8'h00;
    end else if (ce) begin
      hw_prev_q <= hw_lvl;
      event_pending_reg <= (event_pending_reg
        & ~((src_q == dcm_pkg::SRC_EVENT) ? serv_mask : dcm_pkg::VEC_RST))
        | hw_rise | manual_set;
      quick_pending <= (quick_pending
        & ~((eval_q_end && (src_q == dcm_pkg::SRC_QUICK)) ? 8'(code_bit(idx_q)) : 8'h00))
        | q_trig;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      chained_event_reg <= dcm_pkg::VEC_RST;
      irq_pending_reg <= dcm_pkg::VEC_RST;
    end else if (ce) begin
      chained_event_reg <= (chained_event_reg & ~chain_clear
        & ~((src_q == dcm_pkg::SRC_CHAIN) ? serv_mask : dcm_pkg::VEC_RST)) | chn_set;
      irq_pending_reg <= (irq_pending_reg & ~irq_clear) | irq_set;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      event_missed_reg <= dcm_pkg::VEC_RST;
      null_error <= 1'b0;
    end else if (ce) begin
      event_missed_reg <= (event_missed_reg & ~missed_clear) | null_mask
        | ((hw_rise | manual_set) & event_pending_reg) | (chn_set & chained_event_reg);
      null_error <= (null_error && !(|missed_clear)) || (|null_mask);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= dcm_pkg::ST_IDLE;
      src_q <= dcm_pkg::SRC_EVENT;
      cur_q <= 7'h00;
      idx_q <= 6'h00;
      lcnt_q <= 3'h0;
    end else if (ce) begin
      case (state_q)
        dcm_pkg::ST_IDLE: begin
          lcnt_q <= 3'h0;
          if (qpick[6]) begin
            state_q <= dcm_pkg::ST_EVAL;
            src_q <= dcm_pkg::SRC_QUICK;
            idx_q <= qpick[5:0];
            cur_q <= qset_q[qpick[2:0]];
          end else if (dpick[6]) begin
            state_q <= dcm_pkg::ST_EVAL;
            src_q <= event_pending_reg[dpick[5:0]] ? dcm_pkg::SRC_EVENT : dcm_pkg::SRC_CHAIN;
            idx_q <= dpick[5:0];
            cur_q <= {1'b0, dpick[5:0]};
          end
        end
        dcm_pkg::ST_EVAL: begin
          state_q <= (is_null || is_dummy) ? dcm_pkg::ST_IDLE : dcm_pkg::ST_SUBMIT;
        end
        dcm_pkg::ST_SUBMIT: begin
          if (hs) begin
            state_q <= is_final ? dcm_pkg::ST_LINK : dcm_pkg::ST_IDLE;
          end
        end
        dcm_pkg::ST_LINK: begin
          lcnt_q <= lcnt_q + 3'h1;
          if (!copy_we || (lcnt_q == 3'h7)) begin
            state_q <= dcm_pkg::ST_IDLE;
          end
        end
        default: state_q <= dcm_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rq_valid_q <= 1'b0;
      rq_set_q <= 7'h00;
      rq_code_q <= 6'h00;
      rq_chain_q <= 1'b0;
      rq_irq_q <= 1'b0;
    end else if (ce) begin
      if (eval_q_end && !is_null && !is_dummy) begin
        rq_valid_q <= 1'b1;
        rq_set_q <= cur_q;
        rq_code_q <= code;
        rq_chain_q <= want_chain && !cfg[dcm_pkg::CFG_EARLY];
        rq_irq_q <= want_irq && !cfg[dcm_pkg::CFG_EARLY];
      end else if (hs) begin
        rq_valid_q <= 1'b0;
      end
    end
  end
endmodule

// [dcm_link_asserts.sv]
// Checks on the request and completion link
`timescale 1ns/100ps
module dcm_link_asserts (
  input wire logic clock, // Clock
  input wire logic reset, // Reset
  input wire logic rq_valid, // Request
  input wire logic rq_ready, // Ready
  input wire logic [6:0] rq_set, // Set
  input wire logic [5:0] rq_code, // Code
  input wire logic rq_chain, // Chain wanted
  input wire logic rq_irq, // Irq wanted
  input wire logic done_valid, // Done pulse
  input wire logic [5:0] done_code, // Done code
  input wire logic done_chain, // Done chain
  input wire logic done_irq // Done irq
);
  logic [5:0] code_q;
  logic chain_q;
  logic irq_q;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Request in flight
  always_ff @(posedge clock) begin
    if (reset) begin
      code_q <= 6'h00;
      chain_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (rq_valid && rq_ready) begin
      code_q <= rq_code;
      chain_q <= rq_chain;
      irq_q <= rq_irq;
    end
  end
  reset_idle_a: assert property ($fell(reset) |-> rq_ready && !rq_valid && !done_valid)
    else $error("link busy after reset");
  request_hold_a: assert property (rq_valid && !rq_ready |=> rq_valid && $stable(rq_set)
    && $stable(rq_code) && $stable(rq_chain) && $stable(rq_irq))
    else $error("request changed before taken");
  take_clear_a: assert property (rq_valid && rq_ready |=> !rq_ready && !rq_valid)
    else $error("request not retired");
  done_busy_a: assert property (done_valid |-> rq_ready && !$past(rq_ready))
    else $error("completion without transfer");
  done_pulse_a: assert property (done_valid |=> !done_valid)
    else $error("completion longer than a cycle");
  done_code_a: assert property (done_valid |-> done_code == code_q && done_chain == chain_q
    && done_irq == irq_q) else $error("completion code differs");
  done_flags_a: assert property (done_valid |-> done_chain || done_irq)
    else $error("completion without flags");
  early_quiet_a: assert property (!rq_ready && !chain_q && !irq_q |-> !done_valid)
    else $error("code returned for early request");
  cover property (done_valid && done_irq);
  cover property (done_valid && done_chain);
  cover property (rq_valid && rq_ready && !rq_chain && !rq_irq);
  cover property (rq_valid && !rq_ready);
endmodule

// [tb_top.sv]
// Bench for the channel and transfer controller pair
`timescale 1ns/100ps
module tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic dest_done = 1'b0;
  logic pm_we = 1'b0, pm_re = 1'b0, qmap_we = 1'b0, rd_pend = 1'b0;
  logic [63:0] hw_event = '0, manual_set = '0, chain_clear = '0, irq_clear = '0;
  logic [63:0] missed_clear = '0;
  logic [63:0] event_pending_reg, chained_event_reg, irq_pending_reg, event_missed_reg;
  logic [31:0] pm_addr = '0, pm_wdata = '0, rnd = 32'h4d51, cfg0, pm_rdata;
  logic [2:0] qmap_sel = '0, qmap_word = '0;
  logic [6:0] qmap_set = '0, xfer_set;
  logic [7:0] quick_enable = '0, quick_pending;
  logic xfer_active, null_error;
  int errors = 0, checked = 0;
  logic [6:0] exp_set[$];
  logic [31:0] exp_rd[$];
  dcm_if dcm_if_inst ();
  dcm_channel_ctrl dcm_channel_ctrl_inst (.clock(clock), .reset(reset), .ce(ce),
    .link(dcm_if_inst), .hw_event(hw_event), .manual_set(manual_set), .pm_we(pm_we),
    .pm_re(pm_re), .pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_rdata(pm_rdata),
    .qmap_we(qmap_we), .qmap_sel(qmap_sel), .qmap_set(qmap_set), .qmap_word(qmap_word),
    .quick_enable(quick_enable), .chain_clear(chain_clear), .irq_clear(irq_clear),
    .missed_clear(missed_clear), .event_pending_reg(event_pending_reg),
    .chained_event_reg(chained_event_reg), .irq_pending_reg(irq_pending_reg),
    .event_missed_reg(event_missed_reg), .quick_pending(quick_pending),
    .null_error(null_error));
  dcm_xfer_ctrl dcm_xfer_ctrl_inst (.clock(clock), .reset(reset), .ce(ce),
    .link(dcm_if_inst), .dest_done(dest_done), .xfer_active(xfer_active), .xfer_set(xfer_set));
  dcm_link_asserts dcm_link_asserts_inst (.clock(clock), .reset(reset),
    .rq_valid(dcm_if_inst.rq_valid), .rq_ready(dcm_if_inst.rq_ready),
    .rq_set(dcm_if_inst.rq_set), .rq_code(dcm_if_inst.rq_code),
    .rq_chain(dcm_if_inst.rq_chain), .rq_irq(dcm_if_inst.rq_irq),
    .done_valid(dcm_if_inst.done_valid), .done_code(dcm_if_inst.done_code),
    .done_chain(dcm_if_inst.done_chain), .done_irq(dcm_if_inst.done_irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] pa(input logic [6:0] s, input logic [2:0] w);
    return dcm_pkg::PM_BASE + {20'h0, s, w, 2'b00};
  endfunction
  function automatic logic [31:0] mk_cfg(input logic [5:0] c, input int f);
    return ({26'h0, c} << dcm_pkg::CFG_CODE_LSB) | 32'(f);
  endfunction
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge clock);
    pm_we = 1'b1;
    pm_addr = a;
    pm_wdata = d;
    @(negedge clock);
    pm_we = 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(negedge clock);
    pm_re = 1'b1;
    pm_addr = a;
    exp_rd.push_back(e);
    @(negedge clock);
    pm_re = 1'b0;
  endtask
  task automatic pulse(input int k, input logic [63:0] m);
    @(negedge clock);
    case (k)
      0: manual_set = m;
      1: irq_clear = m;
      default: missed_clear = m;
    endcase
    @(negedge clock);
    manual_set = '0;
    irq_clear = '0;
    missed_clear = '0;
  endtask
  // Trigger word t is written last
  task automatic prog(input logic [6:0] s, input logic [2:0] t, input logic [31:0] o,
      input logic [31:0] cnt, input logic [15:0] third);
    logic [31:0] d[8];
    d = '{default: 32'h0};
    d[dcm_pkg::W_CFG] = o;
    d[dcm_pkg::W_CNT] = cnt;
    d[dcm_pkg::W_LINK] = {16'h0, dcm_pkg::NULL_LINK};
    d[dcm_pkg::W_CNT3] = {16'h0, third};
    for (int i = 0; i < 8; i++) begin
      if (i != t) wr(pa(s, 3'(i)), d[i]);
    end
    wr(pa(s, t), d[t]);
  endtask
  task automatic finish_xfer();
    for (int i = 0; i < 50 && xfer_active !== 1'b1; i++) @(negedge clock);
    cmp("xfer_active", 64'h1, 64'(xfer_active));
    dest_done = 1'b1;
    @(negedge clock);
    dest_done = 1'b0;
    repeat (4) @(negedge clock);
  endtask
  initial begin
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    tally_and_finish();
  end
  always @(posedge clock) begin
    if (rd_pend) cmp("pm_rdata", 64'(exp_rd.pop_front()), 64'(pm_rdata));
    if (dcm_if_inst.rq_valid === 1'b1 && dcm_if_inst.rq_ready === 1'b1) begin
      if (exp_set.size() == 0) cmp("unexpected_request", 64'h0, 64'h1);
      else cmp("rq_set", 64'(exp_set.pop_front()), 64'(dcm_if_inst.rq_set));
    end
    rd_pend = pm_re;
  end
  initial begin
    repeat (10) @(negedge clock);
    reset = 1'b0;
    cmp("irq_pending_reg", 64'h0, irq_pending_reg);
    // Quick channel 0 starts on set 0, word 0
    quick_enable = 8'h01;
    cfg0 = mk_cfg(6'h21, 1 << dcm_pkg::CFG_FINAL_IRQ);
    exp_set.push_back(7'h00);
    prog(7'h00, dcm_pkg::W_CFG, cfg0, {16'h1, 16'h4}, 16'h1);
    finish_xfer();
    cmp("irq_pending_reg", 64'h1 << 33, irq_pending_reg);
    pulse(1, 64'h1 << 33);
    quick_enable = 8'h00;
    rd(pa(7'h00, dcm_pkg::W_CNT), 32'h0);
    @(negedge clock);
    qmap_we = 1'b1;
    qmap_sel = 3'h3;
    qmap_set = 7'd100;
    qmap_word = 3'h7;
    @(negedge clock);
    qmap_we = 1'b0;
    quick_enable = 8'h08;
    exp_set.push_back(7'd100);
    prog(7'd100, 3'h7, mk_cfg(6'h0a, (1 << dcm_pkg::CFG_EARLY)
      | (1 << dcm_pkg::CFG_FINAL_CHAIN)), {16'h1, 16'h8}, 16'h1);
    for (int i = 0; i < 20 && null_error !== 1'b1; i++) @(negedge clock);
    cmp("event_missed_reg", 64'h1 << 10, event_missed_reg);
    cmp("null_error", 64'h1, 64'(null_error));
    cmp("chained_event_reg", 64'h0, chained_event_reg);
    cmp("xfer_active", 64'h1, 64'(xfer_active));
    // Second request waits while the first is held
    prog(7'd30, 3'h0, mk_cfg(6'h1e, 0), {16'h1, 16'h4}, 16'h1);
    exp_set.push_back(7'd30);
    pulse(0, 64'h1 << 30);
    finish_xfer();
    finish_xfer();
    quick_enable = 8'h00;
    pulse(2, 64'h1 << 10);
    cmp("null_error", 64'h0, 64'(null_error));
    prog(7'd20, 3'h0, mk_cfg(6'h14, 1 << dcm_pkg::CFG_FINAL_IRQ), {16'h1, 16'h0}, 16'h1);
    pulse(0, 64'h1 << 20);
    for (int i = 0; i < 20 && irq_pending_reg !== 64'h1 << 20; i++) @(negedge clock);
    cmp("irq_pending_reg", 64'h1 << 20, irq_pending_reg);
    cmp("event_missed_reg", 64'h0, event_missed_reg);
    pulse(1, 64'h1 << 20);
    prog(7'd40, 3'h0, mk_cfg(6'h05, (1 << dcm_pkg::CFG_SYNC_FRAME)
      | (1 << dcm_pkg::CFG_INTER_IRQ) | (1 << dcm_pkg::CFG_INTER_CHAIN)), {16'h2, 16'h4}, 16'h2);
    exp_set.push_back(7'd40);
    hw_event = 64'h1 << 40;
    finish_xfer();
    for (int i = 0; i < 20 && event_missed_reg !== 64'h1 << 5; i++) @(negedge clock);
    cmp("irq_pending_reg", 64'h1 << 5, irq_pending_reg);
    cmp("event_missed_reg", 64'h1 << 5, event_missed_reg);
    pulse(1, 64'h1 << 5);
    pulse(2, 64'h1 << 5);
    hw_event = '0;
    exp_set.push_back(7'd40);
    pulse(0, 64'h1 << 40);
    finish_xfer();
    cmp("irq_pending_reg", 64'h0, irq_pending_reg);
    rd(pa(7'd40, dcm_pkg::W_CNT), 32'h0);
    rnd = lfsr(rnd);
    wr(pa(7'd127, 3'h6), rnd);
    rd(pa(7'd127, 3'h6), rnd);
    rnd = lfsr(rnd);
    wr(dcm_pkg::PM_LAST + 32'h1, rnd);
    rd(pa(7'h00, dcm_pkg::W_CFG), cfg0);
    rd(dcm_pkg::PM_BASE - 32'h4, 32'h0);
    repeat (4) @(negedge clock);
    cmp("queued_requests", 64'h0, 64'(exp_set.size()));
    tally_and_finish();
  end
endmodule
